/* File: design/ccw_exec.sv */
// Executor for the clear-register, clear-accumulator, call and watchdog-kick instructions.
// Assumes instructions and register strobes come from logic on the same clock.
// Summary of operation
// - Clear-register writes zero to the addressed file register and sets the zero flag.
// - A call first pushes the current program counter plus one onto the stack.
// - A call loads its eleven-bit literal into program counter bits ten to zero.
// - A call takes program counter bits twelve and eleven from latch bits four and three.
// - A call is one word and takes two instruction cycles.
// - Clear-accumulator loads zero into the accumulator and sets the zero flag.
// - Watchdog kick clears the watchdog counter and its prescaler.
// - Watchdog kick sets both the expired and sleep-entered status bits to one.
`timescale 1ns/1ns
module ccw_exec
    import ccw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ccw_pkg::INSTR_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic sleep_req,
    input wire logic [ccw_pkg::BUS_ADDR_W-1:0] bus_addr,
    input wire logic [ccw_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    output logic [ccw_pkg::DATA_W-1:0] bus_rdata,
    output logic [ccw_pkg::PC_W-1:0] pc,
    output logic [ccw_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic watchdog_expired_flag_n,
    output logic sleep_entered_flag_n,
    output logic [ccw_pkg::DATA_W-1:0] watchdog_count,
    output logic [ccw_pkg::PC_W-1:0] stack_top,
    output logic file_we,
    output logic [ccw_pkg::FADDR_W-1:0] file_addr,
    output logic [ccw_pkg::DATA_W-1:0] file_wdata,
    output logic busy
);

    ccw_state_t state_q;
    ccw_state_t state_d;
    logic busy_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [DATA_W-1:0] acc_q;
    logic zero_q;
    logic expired_n_q;
    logic sleep_n_q;
    logic [DATA_W-1:0] wdt_q;
    logic [DATA_W-1:0] prescale_q;
    logic [LATCH_W-1:0] latch_q;
    logic [STACK_PTR_W-1:0] sp_q;
    logic [STACK_PTR_W-1:0] sp_d;
    logic file_we_q;
    logic [FADDR_W-1:0] file_addr_q;
    logic [DATA_W-1:0] rdata_q;

    // Decode. The word fetched during a call's second cycle is discarded.
    wire take = instr_valid && (state_q == ST_EXEC);
    wire is_clear_reg = (instr[13:7] == OPC_CLEAR_REG);
    wire is_clear_acc = (instr[13:7] == OPC_CLEAR_ACC);
    wire is_call = (instr[13:11] == OPC_CALL);
    wire is_kick = (instr == OPC_WATCHDOG_KICK);
    wire clear_reg_op = take && is_clear_reg;
    wire clear_accumulator_op = take && is_clear_acc;
    wire call_op = take && is_call;
    wire watchdog_kick_op = take && is_kick;

    wire [PC_W-1:0] pc_next = pc_q + 13'h0001;
    wire [PC_W-1:0] call_target = {latch_q[LATCH_CALL_HI:LATCH_CALL_LO], instr[LIT_W-1:0]};
    assign pc_d = call_op ? call_target : (take ? pc_next : pc_q);
    assign state_d = call_op ? ST_FLUSH : ST_EXEC;
    assign sp_d = call_op ? sp_q + 3'h1 : sp_q;

    // Watchdog prescaler carries into the counter; a full wrap marks expiry.
    wire prescale_wrap = (prescale_q == 8'hff);
    wire wdt_wrap = prescale_wrap && (wdt_q == 8'hff);

    // Register port decode.
    wire sel_latch = (bus_addr == REG_PC_HIGH_LATCH);
    wire [DATA_W-1:0] status_word = {5'h00, expired_n_q, sleep_n_q, zero_q};
    wire [DATA_W-1:0] rdata_d =
        !bus_re ? rdata_q :
        (bus_addr == REG_PC_HIGH_LATCH) ? {3'h0, latch_q} :
        (bus_addr == REG_ACCUMULATOR) ? acc_q :
        (bus_addr == REG_STATUS) ? status_word :
        (bus_addr == REG_PC_LOW) ? pc_q[7:0] :
        (bus_addr == REG_PC_HIGH) ? {3'h0, pc_q[12:8]} :
        (bus_addr == REG_WATCHDOG_COUNT) ? wdt_q :
        (bus_addr == REG_STACK_TOP_LOW) ? stack_top[7:0] :
        (bus_addr == REG_STACK_TOP_HIGH) ? {3'h0, stack_top[12:8]} :
        8'h00;

    ccw_stack_mem u_stack (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .we(call_op),
        .waddr(sp_d),
        .wdata(pc_next),
        .raddr(sp_d),
        .rdata(stack_top)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_EXEC;
            busy_q <= 1'b0;
            pc_q <= PC_RESET;
            sp_q <= 3'h0;
        end else if (ce) begin
            state_q <= state_d;
            busy_q <= (state_d == ST_FLUSH);
            pc_q <= pc_d;
            sp_q <= sp_d;
        end
    end

    // Both clears force zero, so the zero flag is set by either of them.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_q <= ACC_RESET;
            zero_q <= 1'b0;
            file_we_q <= 1'b0;
            file_addr_q <= 7'h00;
        end else if (ce) begin
            if (clear_accumulator_op) begin
                acc_q <= ACC_RESET;
            end
            if (clear_accumulator_op || clear_reg_op) begin
                zero_q <= 1'b1;
            end
            file_we_q <= clear_reg_op;
            if (clear_reg_op) begin
                file_addr_q <= instr[FADDR_W-1:0];
            end
        end
    end

    // A kick in the same cycle as an expiry or sleep request wins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdt_q <= WATCHDOG_RESET;
            prescale_q <= WATCHDOG_RESET;
            expired_n_q <= FLAG_N_RESET;
            sleep_n_q <= FLAG_N_RESET;
        end else if (ce) begin
            if (watchdog_kick_op) begin
                wdt_q <= WATCHDOG_RESET;
                prescale_q <= WATCHDOG_RESET;
                expired_n_q <= 1'b1;
                sleep_n_q <= 1'b1;
            end else begin
                prescale_q <= prescale_q + 8'h01;
                if (prescale_wrap) begin
                    wdt_q <= wdt_q + 8'h01;
                end
                if (wdt_wrap) begin
                    expired_n_q <= 1'b0;
                end
                if (sleep_req) begin
                    sleep_n_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_q <= LATCH_RESET;
            rdata_q <= 8'h00;
        end else if (ce) begin
            if (bus_we && sel_latch) begin
                latch_q <= bus_wdata[LATCH_W-1:0];
            end
            rdata_q <= bus_re ? rdata_d : 8'h00;
        end
    end

    assign bus_rdata = rdata_q;
    assign pc = pc_q;
    assign acc = acc_q;
    assign zero_flag = zero_q;
    assign watchdog_expired_flag_n = expired_n_q;
    assign sleep_entered_flag_n = sleep_n_q;
    assign watchdog_count = wdt_q;
    assign file_we = file_we_q;
    assign file_addr = file_addr_q;
    assign file_wdata = 8'h00;
    assign busy = busy_q;

    property p_clear_reg;
        @(posedge clock) disable iff (rst)
        (ce && clear_reg_op) |=> (file_we && file_addr == $past(instr[6:0]) && file_wdata == 8'h00 && zero_flag);
    endproperty
    a_clear_reg: assert property (p_clear_reg) else $error("clear-register did not clear target");

    property p_call_push;
        @(posedge clock) disable iff (rst)
        (ce && call_op) |=> (stack_top == $past(pc) + 13'h0001);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push return address");

    property p_call_low;
        @(posedge clock) disable iff (rst)
        (ce && call_op) |=> (pc[10:0] == $past(instr[10:0]));
    endproperty
    a_call_low: assert property (p_call_low) else $error("call literal not loaded");

    property p_call_high;
        @(posedge clock) disable iff (rst)
        (ce && call_op) |=> (pc[12:11] == $past(latch_q[4:3]));
    endproperty
    a_call_high: assert property (p_call_high) else $error("call upper bits not from latch");

    property p_call_two;
        @(posedge clock) disable iff (rst)
        (ce && call_op) ##1 ce |-> (busy ##1 !busy);
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles");

    property p_clear_acc;
        @(posedge clock) disable iff (rst)
        (ce && clear_accumulator_op) |=> (acc == 8'h00 && zero_flag && !busy);
    endproperty
    a_clear_acc: assert property (p_clear_acc) else $error("clear-accumulator failed");

    property p_kick_count;
        @(posedge clock) disable iff (rst)
        (ce && watchdog_kick_op) |=> (watchdog_count == 8'h00 && prescale_q == 8'h00);
    endproperty
    a_kick_count: assert property (p_kick_count) else $error("kick did not clear watchdog");

    property p_kick_flags;
        @(posedge clock) disable iff (rst)
        (ce && watchdog_kick_op) |=> (watchdog_expired_flag_n && sleep_entered_flag_n);
    endproperty
    a_kick_flags: assert property (p_kick_flags) else $error("kick did not set status bits");

    property p_clear_reg_one;
        @(posedge clock) disable iff (rst)
        (ce && clear_reg_op) |=> (!busy && pc == $past(pc) + 13'h0001);
    endproperty
    a_clear_reg_one: assert property (p_clear_reg_one) else $error("clear-register not one cycle");

    property p_kick_one;
        @(posedge clock) disable iff (rst)
        (ce && watchdog_kick_op) |=> (!busy && pc == $past(pc) + 13'h0001);
    endproperty
    a_kick_one: assert property (p_kick_one) else $error("kick not one cycle");

    property p_discard;
        @(posedge clock) disable iff (rst)
        (ce && busy) |=> (pc == $past(pc) && !file_we);
    endproperty
    a_discard: assert property (p_discard) else $error("word in call discard cycle was executed");

    property p_file_we_pulse;
        @(posedge clock) disable iff (rst)
        (ce && file_we && !clear_reg_op) |=> !file_we;
    endproperty
    a_file_we_pulse: assert property (p_file_we_pulse) else $error("file write longer than one cycle");

    property p_clear_acc_no_write;
        @(posedge clock) disable iff (rst)
        (ce && clear_accumulator_op) |=> !file_we;
    endproperty
    a_clear_acc_no_write: assert property (p_clear_acc_no_write) else $error("clear-accumulator wrote a register");

    property p_clear_reg_acc;
        @(posedge clock) disable iff (rst)
        (ce && clear_reg_op) |=> (acc == $past(acc));
    endproperty
    a_clear_reg_acc: assert property (p_clear_reg_acc) else $error("clear-register touched the accumulator");

    property p_zero_hold;
        @(posedge clock) disable iff (rst)
        (ce && !clear_reg_op && !clear_accumulator_op) |=> (zero_flag == $past(zero_flag));
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero flag changed without a clear");

    property p_call_sp;
        @(posedge clock) disable iff (rst)
        (ce && call_op) |=> (sp_q == $past(sp_q) + 3'h1);
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call did not advance the stack pointer");

    property p_sleep_hold;
        @(posedge clock) disable iff (rst)
        (ce && !watchdog_kick_op && !sleep_req) |=> (sleep_entered_flag_n == $past(sleep_entered_flag_n));
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep status changed without a kick");

    property p_expiry;
        @(posedge clock) disable iff (rst)
        (ce && !watchdog_kick_op && watchdog_count == 8'hff && prescale_q == 8'hff) |=> !watchdog_expired_flag_n;
    endproperty
    a_expiry: assert property (p_expiry) else $error("watchdog wrap did not mark expiry");

    property p_unknown_op;
        @(posedge clock) disable iff (rst)
        (ce && take && !is_clear_reg && !is_clear_acc && !is_call && !is_kick)
            |=> (pc == $past(pc) + 13'h0001 && !file_we && !busy);
    endproperty
    a_unknown_op: assert property (p_unknown_op) else $error("unknown word did more than advance");

endmodule // ccw_exec

/* File: design/ccw_pkg.sv */
// Constants shared by the instruction executor and its return-stack memory.
// Assumes a single clock domain and the plain register port of the executor.
package ccw_pkg;

    localparam int unsigned INSTR_W = 14;
    localparam int unsigned PC_W = 13;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned LIT_W = 11;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned STACK_PTR_W = 3;
    localparam int unsigned BUS_ADDR_W = 4;
    localparam int unsigned LATCH_W = 5;

    // Opcode fields compared against the top bits of the instruction word, or against the whole word for the watchdog kick.
    localparam logic [6:0] OPC_CLEAR_REG = 7'h03;
    localparam logic [6:0] OPC_CLEAR_ACC = 7'h02;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [13:0] OPC_WATCHDOG_KICK = 14'h0064;

    // Field positions of the program-counter high latch used by a call.
    localparam int unsigned LATCH_CALL_HI = 4;
    localparam int unsigned LATCH_CALL_LO = 3;

    // Register port offsets.
    localparam logic [3:0] REG_PC_HIGH_LATCH = 4'h0;
    localparam logic [3:0] REG_ACCUMULATOR = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_PC_LOW = 4'h3;
    localparam logic [3:0] REG_PC_HIGH = 4'h4;
    localparam logic [3:0] REG_WATCHDOG_COUNT = 4'h5;
    localparam logic [3:0] REG_STACK_TOP_LOW = 4'h6;
    localparam logic [3:0] REG_STACK_TOP_HIGH = 4'h7;

    // Status register bit positions.
    localparam int unsigned STATUS_ZERO_BIT = 0;
    localparam int unsigned STATUS_SLEEP_N_BIT = 1;
    localparam int unsigned STATUS_EXPIRED_N_BIT = 2;

    // Reset values.
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] LATCH_RESET = 5'h00;
    localparam logic [7:0] WATCHDOG_RESET = 8'h00;
    localparam logic FLAG_N_RESET = 1'b1;

    typedef enum logic [0:0] {
        ST_EXEC = 1'b0,
        ST_FLUSH = 1'b1
    } ccw_state_t;

endpackage

/* File: design/ccw_stack_mem.sv */
// Return-address memory for the subroutine stack, eight entries deep.
// Assumes the caller gives the read address of the next stack top each cycle.
`timescale 1ns/1ns
module ccw_stack_mem
    import ccw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic we,
    input wire logic [ccw_pkg::STACK_PTR_W-1:0] waddr,
    input wire logic [ccw_pkg::PC_W-1:0] wdata,
    input wire logic [ccw_pkg::STACK_PTR_W-1:0] raddr,
    output logic [ccw_pkg::PC_W-1:0] rdata
);

    logic [PC_W-1:0] mem_q [STACK_DEPTH];
    logic [PC_W-1:0] rdata_q;
    wire bypass = we && (waddr == raddr);
    wire [PC_W-1:0] rdata_d = bypass ? wdata : mem_q[raddr];

    always_ff @(posedge clock) begin
        if (ce && we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Write-through keeps the top visible in the cycle right after a push.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= PC_RESET;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule // ccw_stack_mem

/* File: bench/ccw_exec_tb_top.sv */
// Self-checking bench for the clear, call and watchdog-kick executor.
// Assumes a single 20 MHz clock and drives every port itself, with no partner model.
`timescale 1ns/1ns
module ccw_exec_tb_top;
    import ccw_pkg::*;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'b0;
    logic sleep_req = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_we = 1'b0;
    logic bus_re = 1'b0;
    logic [7:0] bus_rdata, acc, watchdog_count, file_wdata;
    logic [12:0] pc, stack_top, ep;
    logic zero_flag, watchdog_expired_flag_n, sleep_entered_flag_n, file_we, busy;
    logic [6:0] file_addr;
    int num_errors = 0;
    int tests_run = 0;

    ccw_exec ccw_exec_i (.clock(clock), .rst(rst), .ce(ce), .instr(instr), .instr_valid(instr_valid),
        .sleep_req(sleep_req), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
        .bus_re(bus_re), .bus_rdata(bus_rdata), .pc(pc), .acc(acc), .zero_flag(zero_flag),
        .watchdog_expired_flag_n(watchdog_expired_flag_n), .sleep_entered_flag_n(sleep_entered_flag_n),
        .watchdog_count(watchdog_count), .stack_top(stack_top), .file_we(file_we),
        .file_addr(file_addr), .file_wdata(file_wdata), .busy(busy));

    always #25 clock = ~clock;

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        #1;
    endtask

    // Results are looked at 1 ns after the taking edge, once its updates have landed.
    task automatic exec(input logic [13:0] w);
        @(posedge clock);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_we <= 1'b1;
        @(posedge clock);
        bus_we <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic bus_read(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clock);
        bus_addr <= a;
        bus_re <= 1'b1;
        @(posedge clock);
        bus_re <= 1'b0;
        #1;
        chk(nm, {8'h00, exp}, {8'h00, bus_rdata});
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        $display("Error timeout expected %h seen %h", 1'b0, 1'b1);
        end_of_test();
    end

    initial begin
        do_reset();
        bus_read(REG_STATUS, 8'h06, "status_reset");
        bus_write(REG_PC_HIGH_LATCH, 8'h18);
        bus_read(REG_PC_HIGH_LATCH, 8'h18, "latch");
        bus_write(REG_ACCUMULATOR, 8'hFF);
        bus_read(REG_ACCUMULATOR, 8'h00, "acc_read_only");
        bus_read(4'hC, 8'h00, "unmapped");
        exec({OPC_CLEAR_ACC, 7'h55});
        chk("acc", 16'h0000, {8'h00, acc});
        chk("zero_acc", 16'h0001, {15'h0, zero_flag});
        chk("pc_acc", 16'h0001, {3'h0, pc});
        do_reset();
        ep = 13'h0000;
        for (int i = 0; i < 2; i++) begin
            exec({OPC_CLEAR_REG, (i == 0) ? 7'h00 : 7'h7F});
            ep = ep + 13'h0001;
            chk("file_we", 16'h0001, {15'h0, file_we});
            chk("file_addr", (i == 0) ? 16'h0000 : 16'h007F, {9'h0, file_addr});
            chk("file_wdata", 16'h0000, {8'h00, file_wdata});
            chk("zero_reg", 16'h0001, {15'h0, zero_flag});
            chk("pc_reg", {3'h0, ep}, {3'h0, pc});
            @(posedge clock);
            #1;
            chk("file_we_end", 16'h0000, {15'h0, file_we});
        end
        // Back to back: clear-accumulator then clear-register with no gap.
        @(posedge clock);
        instr <= {OPC_CLEAR_ACC, 7'h00};
        instr_valid <= 1'b1;
        @(posedge clock);
        instr <= {OPC_CLEAR_REG, 7'h2A};
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        ep = ep + 13'h0002;
        chk("b2b_addr", 16'h002A, {9'h0, file_addr});
        chk("b2b_pc", {3'h0, ep}, {3'h0, pc});
        // Call with the word after it offered during the discard cycle.
        bus_write(REG_PC_HIGH_LATCH, 8'h18);
        @(posedge clock);
        instr <= {OPC_CALL, 11'h7FF};
        instr_valid <= 1'b1;
        @(posedge clock);
        instr <= {OPC_CLEAR_REG, 7'h11};
        #1;
        chk("call_pc", 16'h1FFF, {3'h0, pc});
        chk("call_push", {3'h0, ep + 13'h0001}, {3'h0, stack_top});
        chk("busy", 16'h0001, {15'h0, busy});
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        chk("busy_end", 16'h0000, {15'h0, busy});
        chk("discard_we", 16'h0000, {15'h0, file_we});
        chk("discard_pc", 16'h1FFF, {3'h0, pc});
        ep = ep + 13'h0001;
        bus_read(REG_STACK_TOP_LOW, ep[7:0], "stack_lo");
        bus_read(REG_STACK_TOP_HIGH, {3'h0, ep[12:8]}, "stack_hi");
        // Only latch bits 4:3 reach the counter; the push wraps past the top.
        bus_write(REG_PC_HIGH_LATCH, 8'h07);
        exec({OPC_CALL, 11'h2A5});
        chk("call2_pc", 16'h02A5, {3'h0, pc});
        chk("call2_push", 16'h0000, {3'h0, stack_top});
        bus_read(REG_PC_LOW, 8'hA5, "pc_lo");
        ce <= 1'b0;
        exec({OPC_CLEAR_REG, 7'h05});
        chk("frozen_pc", 16'h02A5, {3'h0, pc});
        chk("frozen_we", 16'h0000, {15'h0, file_we});
        ce <= 1'b1;
        // Watchdog: the kick lands late in a prescaler period so a stale prescaler shows.
        do_reset();
        repeat (600) @(posedge clock);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        #1;
        chk("wd_run", 16'h0002, {8'h00, watchdog_count});
        chk("sleep_n_low", 16'h0000, {15'h0, sleep_entered_flag_n});
        repeat (130) @(posedge clock);
        exec(14'h0065);
        chk("near_kick", 16'h0002, {8'h00, watchdog_count});
        chk("near_kick_sleep", 16'h0000, {15'h0, sleep_entered_flag_n});
        exec(OPC_WATCHDOG_KICK);
        chk("kick_count", 16'h0000, {8'h00, watchdog_count});
        chk("kick_sleep_n", 16'h0001, {15'h0, sleep_entered_flag_n});
        chk("kick_expired_n", 16'h0001, {15'h0, watchdog_expired_flag_n});
        chk("kick_pc", 16'h0002, {3'h0, pc});
        repeat (100) @(posedge clock);
        #1;
        chk("prescaler_cleared", 16'h0000, {8'h00, watchdog_count});
        repeat (200) @(posedge clock);
        bus_read(REG_WATCHDOG_COUNT, 8'h01, "wd_after_kick");
        // Expiry falls exactly 65536 edges after the kick, so the kick must be seen to undo it.
        repeat (65233) @(posedge clock);
        #1;
        chk("expired_early", 16'h0001, {15'h0, watchdog_expired_flag_n});
        @(posedge clock);
        #1;
        chk("expired_n_low", 16'h0000, {15'h0, watchdog_expired_flag_n});
        exec(OPC_WATCHDOG_KICK);
        chk("rekick_expired_n", 16'h0001, {15'h0, watchdog_expired_flag_n});
        chk("rekick_count", 16'h0000, {8'h00, watchdog_count});
        end_of_test();
    end
endmodule // ccw_exec_tb_top
